// file: rtl/tmd_pkg.sv
// Constants, types and register map of the transient motion detector.
// Assumes an 8-bit register port and 8g-scaled signed samples.
package tmd_pkg;

  // Register offsets on the host register port.
  localparam logic [7:0] REG_CONFIG    = 8'h1D;
  localparam logic [7:0] REG_SOURCE    = 8'h1E;
  localparam logic [7:0] REG_THRESHOLD = 8'h1F;
  localparam logic [7:0] REG_COUNT     = 8'h20;

  // Configuration register fields.
  localparam int CFG_BYPASS_BIT = 0;
  localparam int CFG_XEN_BIT    = 1;
  localparam int CFG_LATCH_BIT  = 4;
  localparam int CFG_USED_W     = 5;

  // Source register fields; axis pair i sits at bits 2i (polarity) and 2i+1 (hit).
  localparam int SRC_ACTIVE_BIT = 6;

  // Threshold register fields.
  localparam int THS_STYLE_BIT = 7;
  localparam int THS_LIMIT_W   = 7;

  // Reset values.
  localparam logic [4:0] CONFIG_RESET    = 5'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET     = 8'h00;

  // With low noise on, 4g at 0.063g per count is 63 counts.
  localparam logic [6:0] LOW_NOISE_LIMIT_CAP = 7'h3F;

  // Debounce step timing; every tabled step is a multiple of 1.25 ms.
  localparam int CLK_PERIOD_NS  = 20;
  localparam int STEP_UNIT_NS   = 1250000;
  localparam int STEP_UNIT_CYC  = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sample rate settings, fastest first.
  localparam logic [2:0] RATE_800 = 3'h0;
  localparam logic [2:0] RATE_400 = 3'h1;
  localparam logic [2:0] RATE_200 = 3'h2;
  localparam logic [2:0] RATE_100 = 3'h3;
  localparam logic [2:0] RATE_50  = 3'h4;
  localparam logic [2:0] RATE_12  = 3'h5;

  // High-pass corner: the running mean moves by 1/2^HPF_SHIFT per sample.
  localparam int HPF_SHIFT = 4;

  typedef enum logic [1:0] {
    OS_NORMAL,
    OS_LOW_NOISE_LP,
    OS_FINE_RES,
    OS_LOW_POWER
  } tmd_os_mode_e;

  // One register access request from the serial port front end.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmd_reg_req_s;

  // One signed sample per axis, X in the low byte.
  typedef struct packed {
    logic signed [7:0] z;
    logic signed [7:0] y;
    logic signed [7:0] x;
  } tmd_axes_s;

endpackage

// file: rtl/tmd_axis.sv
// One axis of the transient detector: high-pass filter, threshold compare, debounce.
// Assumes samples arrive as one-cycle valid pulses and steps come from a divider.
`timescale 1ns/1ps
module tmd_axis
  import tmd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              sampleValid,
  input  wire logic signed [7:0] sample,
  input  wire logic              bypass,
  input  wire logic [6:0]        limit,
  input  wire logic              clearStyle,
  input  wire logic [7:0]        countLimit,
  input  wire logic              step,
  output logic                   hitPulse,
  output logic                   hitNeg
);

  logic signed [15:0] meanAcc;
  logic signed [8:0]  filtered;
  logic [7:0]         debCnt;
  logic [7:0]         next_debCnt;

  // Difference between the sample and the running mean, in 9.8 fixed point.
  wire logic signed [16:0] diff     = {sample[7], sample, 8'h00} - {meanAcc[15], meanAcc};
  wire logic signed [8:0]  hpOut    = diff[16:8];
  wire logic signed [8:0]  next_filt = bypass ? 9'(sample) : hpOut;
  wire logic signed [16:0] meanStep = diff >>> HPF_SHIFT;

  // Magnitude over the full 8g span whatever the output range.
  wire logic [8:0] magnitude = filtered[8] ? 9'(-filtered) : 9'(filtered);
  wire logic       overLimit = magnitude > {2'b00, limit};
  wire logic [8:0] cntPlus   = {1'b0, debCnt} + 9'h001;
  wire logic       reached   = overLimit && (cntPlus >= {1'b0, countLimit});

  // The mean keeps running in bypass so switching back does not cause a jolt.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meanAcc  <= 16'sh0000;
      filtered <= 9'sh000;
    end else if (sampleValid) begin
      meanAcc  <= meanAcc + 16'(meanStep);
      filtered <= next_filt;
    end
  end

  // Debounce: count up while over, down or clear on a lapse, never beyond the limit.
  always_comb begin
    next_debCnt = debCnt;
    if (overLimit) begin
      next_debCnt = (debCnt < countLimit) ? cntPlus[7:0] : countLimit;
    end else if (clearStyle) begin
      next_debCnt = 8'h00;
    end else if (debCnt != 8'h00) begin
      next_debCnt = (debCnt > countLimit) ? countLimit : debCnt - 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      debCnt   <= 8'h00;
      hitPulse <= 1'b0;
      hitNeg   <= 1'b0;
    end else begin
      hitPulse <= step && reached;
      hitNeg   <= filtered[8];
      if (step) begin
        debCnt <= next_debCnt;
      end
    end
  end

  a_count_bounded: assert property (@(posedge core_clk) disable iff (sys_rst)
    step |=> debCnt <= $past(countLimit))
    else $error("Debounce counter passed its limit.");

  a_clear_lapse: assert property (@(posedge core_clk) disable iff (sys_rst)
    step && !overLimit && clearStyle |=> debCnt == 8'h00)
    else $error("Clear style did not zero the counter.");

  a_decrement_lapse: assert property (@(posedge core_clk) disable iff (sys_rst)
    step && !overLimit && !clearStyle && debCnt != 8'h00 && debCnt <= countLimit
    |=> debCnt == $past(debCnt) - 8'h01)
    else $error("Decrement style did not lower the counter by one.");

  a_hit_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
    hitPulse |-> $past(step) && $past(overLimit))
    else $error("Hit raised without an over-limit step.");

endmodule

// file: rtl/transient_motion_detector.sv
// Transient motion detector: registers, step divider and event source flags.
// Assumes a serial-port front end issuing one-cycle register requests and
// samples from the front end scaled so one count equals one threshold step.
//
// Function
// - highpass_bypass 0 feeds filtered samples, 1 feeds raw samples.
// - Config bits 3..1 enable Z, Y, X event detection.
// - latch_enable at config bit 4 selects latched or live flags.
// - Reading the source register clears interrupt and all its status bits.
// - While event_active, more axis bits may set; none drop before a read.
// - Latched and event_active: other source bits freeze until read.
// - event_active at source bit 6 shows that some event flag fired.
// - Axis hit bits sit at source bits 5, 3, 1 for Z, Y, X.
// - Polarity bits at 4, 2, 0: 0 positive g, 1 negative g.
// - limit_value is the 7-bit unsigned low field, 0.063g per count.
// - Comparison spans 8g whatever the output full scale.
// - Low noise caps the reachable threshold at 4g.
// - Detection is magnitude strictly greater than the threshold.
// - debounce_style bit 7: 0 decrements, 1 clears the counter on lapse.
// - Debounce count register sets required over-threshold steps; consecutive only in clear style.
// - Step follows sample rate: 1.25, 2.5, 5, 10, 20 ms, capped 20 ms.
// - Fine resolution 2.5 ms at 400 Hz and below; low power 80/160 ms.
// - Event flag always raised; interrupt output only when enabled.
// - Threshold, style and count registers reset to zero.
// - Flag fires when counter reaches count; counter never exceeds count.
// - Decrement style lowers the counter by one per step down to zero.
`timescale 1ns/1ps
module transient_motion_detector
  import tmd_pkg::*;
#(
  parameter int STEP_UNIT_CYCLES = STEP_UNIT_CYC
)
(
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire tmd_reg_req_s regReq,
  output logic [7:0]        regRdData,
  input  wire logic         sampleValid,
  input  wire tmd_axes_s    samples,
  input  wire logic [2:0]   sampleRateSetting,
  input  wire tmd_os_mode_e osMode,
  input  wire logic         lowNoiseEnable,
  input  wire logic         irqEnable,
  output logic              transientIrq
);

  logic [4:0]  configReg;
  logic [7:0]  thresholdReg;
  logic [7:0]  countReg;
  logic [2:0]  hitFlags;
  logic [2:0]  polFlags;
  logic        eventActive;
  logic [31:0] unitCnt;
  logic [7:0]  multCnt;
  logic        step;
  logic        stepSeen;
  logic [2:0]  axisHit;
  logic [2:0]  axisNeg;

  // Debounce step length in 1.25 ms units for a rate and oversampling mode.
  function automatic logic [7:0] step_units(input logic [2:0] rate, input tmd_os_mode_e mode);
    logic [7:0] units;
    units = 8'h10;
    case (rate)
      RATE_800: units = 8'h01;
      RATE_400: units = 8'h02;
      RATE_200: units = 8'h04;
      RATE_100: units = 8'h08;
      RATE_50:  units = 8'h10;
      RATE_12:  units = (mode == OS_NORMAL) ? 8'h10 : 8'h40;
      default:  begin
        case (mode)
          OS_LOW_POWER:    units = 8'h80;
          OS_LOW_NOISE_LP: units = 8'h40;
          default:         units = 8'h10;
        endcase
      end
    endcase
    if (mode == OS_FINE_RES && rate > RATE_800) begin
      units = 8'h02;
    end
    return units;
  endfunction

  // Register decode and field views.
  wire logic       wrConfig    = regReq.wr && regReq.addr == REG_CONFIG;
  wire logic       wrThreshold = regReq.wr && regReq.addr == REG_THRESHOLD;
  wire logic       wrCount     = regReq.wr && regReq.addr == REG_COUNT;
  wire logic       srcRead     = regReq.rd && regReq.addr == REG_SOURCE;
  wire logic       bypass      = configReg[CFG_BYPASS_BIT];
  wire logic [2:0] axisEnable  = configReg[CFG_XEN_BIT +: 3];
  wire logic       latchEnable = configReg[CFG_LATCH_BIT];
  wire logic [6:0] limitValue  = thresholdReg[THS_LIMIT_W-1:0];
  wire logic       clearStyle  = thresholdReg[THS_STYLE_BIT];
  wire logic [7:0] stepUnits   = step_units(sampleRateSetting, osMode);

  // The cap only trims what the comparator sees; software reads back its own value.
  wire logic [6:0] effLimit = (lowNoiseEnable && limitValue > LOW_NOISE_LIMIT_CAP) ?
                              LOW_NOISE_LIMIT_CAP : limitValue;

  // Source register image, bit 7 always zero.
  wire logic [7:0] sourceImage = {1'b0, eventActive, hitFlags[2], polFlags[2],
                                  hitFlags[1], polFlags[1], hitFlags[0], polFlags[0]};

  wire logic [7:0] rdMux = (regReq.addr == REG_CONFIG)    ? {3'b000, configReg} :
                           (regReq.addr == REG_SOURCE)    ? sourceImage :
                           (regReq.addr == REG_THRESHOLD) ? thresholdReg :
                           (regReq.addr == REG_COUNT)     ? countReg : 8'h00;

  // Register writes; the unused high config bits are simply not stored.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      configReg    <= CONFIG_RESET;
      thresholdReg <= THRESHOLD_RESET;
      countReg     <= COUNT_RESET;
    end else begin
      if (wrConfig) begin
        configReg <= regReq.wdata[CFG_USED_W-1:0];
      end
      if (wrThreshold) begin
        thresholdReg <= regReq.wdata;
      end
      if (wrCount) begin
        countReg <= regReq.wdata;
      end
    end
  end

  // Read data is registered and answers one cycle after the request.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regReq.rd) begin
      regRdData <= rdMux;
    end
  end

  // Step divider: a 1.25 ms unit tick, then a count of units per step.
  wire logic unitTick = (unitCnt == 32'(STEP_UNIT_CYCLES - 1));
  wire logic multDone = (multCnt >= stepUnits - 8'h01);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      unitCnt <= 32'h0000_0000;
      multCnt <= 8'h00;
      step    <= 1'b0;
    end else begin
      unitCnt <= unitTick ? 32'h0000_0000 : unitCnt + 32'h0000_0001;
      step    <= unitTick && multDone;
      if (unitTick) begin
        multCnt <= multDone ? 8'h00 : multCnt + 8'h01;
      end
    end
  end

  // One filter and debounce per axis, X first.
  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_axis
      tmd_axis u_axis (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .sampleValid (sampleValid),
        .sample      (samples[8*ax +: 8]),
        .bypass      (bypass),
        .limit       (effLimit),
        .clearStyle  (clearStyle),
        .countLimit  (countReg),
        .step        (step),
        .hitPulse    (axisHit[ax]),
        .hitNeg      (axisNeg[ax])
      );
    end
  endgenerate

  // Qualified events of enabled axes; a latched, active source takes nothing new
  // until it is read, and a hit that meets the read itself is kept, not lost.
  wire logic       frozen  = latchEnable && eventActive && !srcRead;
  wire logic [2:0] enHits  = axisHit & axisEnable;
  wire logic [2:0] newHits = frozen ? 3'b000 : enHits;
  wire logic [2:0] keptHit = srcRead ? 3'b000 : hitFlags;
  wire logic [2:0] keptPol = srcRead ? 3'b000 : polFlags;
  wire logic [2:0] next_hitFlags = keptHit | newHits;
  wire logic [2:0] next_polFlags = (newHits & axisNeg) | (~newHits & keptPol);

  // Latched: sticky until read. Live: follows each step's verdict, set beats read.
  wire logic keptActive  = srcRead ? 1'b0 : eventActive;
  wire logic next_active = latchEnable ? (keptActive | (|enHits)) :
                           (stepSeen ? (|enHits) : keptActive);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hitFlags    <= 3'b000;
      polFlags    <= 3'b000;
      eventActive <= 1'b0;
      stepSeen    <= 1'b0;
    end else begin
      hitFlags    <= next_hitFlags;
      polFlags    <= next_polFlags;
      eventActive <= next_active;
      stepSeen    <= step;
    end
  end

  // The flag is raised regardless; only the pin is gated.
  assign transientIrq = eventActive && irqEnable;

  a_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    transientIrq == (eventActive && irqEnable))
    else $error("Interrupt output does not follow enabled event flag.");

  a_read_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
    srcRead && axisHit == 3'b000 && !stepSeen
    |=> hitFlags == 3'b000 && polFlags == 3'b000 && !eventActive)
    else $error("Source read did not clear status.");

  a_latch_freeze: assert property (@(posedge core_clk) disable iff (sys_rst)
    latchEnable && eventActive && !srcRead && $stable(configReg)
    |=> $stable(hitFlags) && $stable(polFlags) && eventActive)
    else $error("Latched source bits changed before a read.");

  a_bits_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !srcRead |=> (hitFlags & $past(hitFlags)) == $past(hitFlags))
    else $error("Axis hit bit dropped without a source read.");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    regReq.rd && (regReq.addr == REG_CONFIG || regReq.addr == REG_SOURCE)
    |=> regRdData[7] == 1'b0)
    else $error("Reserved bit read back nonzero.");

  a_limit_cap: assert property (@(posedge core_clk) disable iff (sys_rst)
    lowNoiseEnable |-> effLimit <= LOW_NOISE_LIMIT_CAP)
    else $error("Low noise threshold cap not applied.");

  a_hit_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
    !srcRead && $rose(hitFlags[0]) |-> $past(axisEnable[0]))
    else $error("Disabled X axis raised its hit bit.");

  a_step_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
    step |=> !step)
    else $error("Step pulse lasted more than one cycle.");

  // Steps fall only in the cycle after a unit tick of the divider.
  a_step_on_tick: assert property (@(posedge core_clk) disable iff (sys_rst)
    step |-> $past(unitTick))
    else $error("Step pulse without a unit tick.");

  // What the port writes is held from the next cycle on.
  a_config_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrConfig |=> configReg == $past(regReq.wdata[CFG_USED_W-1:0]))
    else $error("Configuration write not stored.");

  a_threshold_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrThreshold |=> thresholdReg == $past(regReq.wdata))
    else $error("Threshold write not stored.");

  a_count_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrCount |=> countReg == $past(regReq.wdata))
    else $error("Debounce count write not stored.");

  // Read data answers one cycle after the strobe and holds until the next one.
  a_source_image: assert property (@(posedge core_clk) disable iff (sys_rst)
    srcRead |=> regRdData == $past(sourceImage))
    else $error("Source read returned a stale image.");

  a_read_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !regReq.rd |=> $stable(regRdData))
    else $error("Read data changed without a read strobe.");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    regReq.rd && (regReq.addr < REG_CONFIG || regReq.addr > REG_COUNT) |=> regRdData == 8'h00)
    else $error("Unmapped offset read back nonzero.");

  // Every hit that lands raises event_active and carries the sign it was seen with.
  a_hit_raises_active: assert property (@(posedge core_clk) disable iff (sys_rst)
    |newHits |=> eventActive && (hitFlags & $past(newHits)) == $past(newHits))
    else $error("Accepted hit did not set its flag and event_active.");

  a_polarity_update: assert property (@(posedge core_clk) disable iff (sys_rst)
    |newHits |=> (polFlags & $past(newHits)) == ($past(axisNeg) & $past(newHits)))
    else $error("Polarity bit does not match the hit sign.");

  a_read_clears_active: assert property (@(posedge core_clk) disable iff (sys_rst)
    srcRead && !(|enHits) |=> !eventActive)
    else $error("Source read left event_active set.");

  // Live flags: event_active is redone at every step from that step's hits.
  a_live_active: assert property (@(posedge core_clk) disable iff (sys_rst)
    !latchEnable && stepSeen |=> eventActive == $past(|enHits))
    else $error("Live event_active does not follow the step's hits.");

  // Disabled Y and Z axes never raise their hit bits.
  a_y_hit_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(hitFlags[1]) |-> $past(axisEnable[1]))
    else $error("Disabled Y axis raised its hit bit.");

  a_z_hit_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(hitFlags[2]) |-> $past(axisEnable[2]))
    else $error("Disabled Z axis raised its hit bit.");

endmodule

// file: verif/tmd_host_model.sv
// Host side of the register port: issues single-byte register writes and reads.
// Assumes the bench calls its tasks and that requests change at the falling edge.
`timescale 1ns/1ps
module tmd_host_model
  import tmd_pkg::*;
(
  input  wire logic       core_clk,
  output tmd_reg_req_s    regReq,
  input  wire logic [7:0] regRdData
);
  initial regReq = '0;

  // A write strobe stands for one rising edge, then drops for at least one cycle.
  task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    regReq.wr    = 1'b1;
    regReq.addr  = addr;
    regReq.wdata = data;
    @(negedge core_clk);
    regReq.wr    = 1'b0;
    regReq.wdata = ~data; // Stale data must not be mistaken for a new write.
  endtask

  // Read data appears the cycle after the edge that took the strobe.
  task automatic rdReg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge core_clk);
    regReq.rd   = 1'b1;
    regReq.addr = addr;
    @(negedge core_clk);
    regReq.rd   = 1'b0;
    data        = regRdData;
  endtask
endmodule

// file: verif/transient_motion_detector_bench.sv
// Self-checking bench for the transient motion detector with a short step unit.
// Assumes bypassed samples reach the comparator one cycle after each valid pulse.
`timescale 1ns/1ps
module transient_motion_detector_bench;
  import tmd_pkg::*;
  localparam int UNIT  = 4;
  localparam int LIMIT = 20000;

  logic         core_clk;
  logic         sys_rst;
  tmd_reg_req_s regReq;
  logic [7:0]   regRdData;
  logic         sampleValid;
  tmd_axes_s    samples;
  logic [2:0]   sampleRateSetting;
  tmd_os_mode_e osMode;
  logic         lowNoiseEnable;
  logic         irqEnable;
  logic         transientIrq;
  int           nErrors;
  int           compares;
  int           cycles = 0;
  logic [7:0]   rdv;
  logic [7:0]   addrs [5];
  logic [7:0]   rates [5];
  logic [7:0]   exps  [5];
  tmd_os_mode_e modes [5];

  transient_motion_detector #(.STEP_UNIT_CYCLES(UNIT)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
    .sampleValid(sampleValid), .samples(samples), .sampleRateSetting(sampleRateSetting),
    .osMode(osMode), .lowNoiseEnable(lowNoiseEnable), .irqEnable(irqEnable),
    .transientIrq(transientIrq));

  tmd_host_model host (.core_clk(core_clk), .regReq(regReq), .regRdData(regRdData));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Cuts a hang short; the ceiling is several times the planned run.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nErrors++;
      endSim();
    end
  end

  task automatic endSim();
    $display("Checks made: %0d, mismatches: %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic sx(input logic signed [7:0] x, input logic signed [7:0] y,
                    input logic signed [7:0] z);
    @(negedge core_clk);
    samples = {z, y, x};
  endtask

  // Reads the source and compares; the read also clears it. The short wait lets a
  // hit still in the pipeline land first, so the clearing read never races it.
  task automatic src(input logic [7:0] exp);
    waitCyc(2);
    host.rdReg(REG_SOURCE, rdv);
    check(rdv, exp);
  endtask

  // Quiet samples, then a clearing read so the next test starts clean.
  task automatic flush();
    sx(0, 0, 0);
    waitCyc(20);
    host.rdReg(REG_SOURCE, rdv);
  endtask

  task automatic setup(input logic [7:0] cfg, input logic [7:0] ths, input logic [7:0] cnt);
    host.wrReg(REG_CONFIG, cfg);
    host.wrReg(REG_THRESHOLD, ths);
    host.wrReg(REG_COUNT, cnt);
    flush();
  endtask

  // A pulse of x for a window, then quiet before the source is read.
  task automatic hitX(input logic signed [7:0] x, input int win);
    sx(x, 0, 0);
    waitCyc(win);
    sx(0, 0, 0);
  endtask

  initial begin
    nErrors = 0;
    compares = 0;
    sys_rst = 1'b1;
    sampleValid = 1'b0;
    samples = '0;
    sampleRateSetting = RATE_800;
    osMode = OS_NORMAL;
    lowNoiseEnable = 1'b0;
    irqEnable = 1'b1;
    addrs = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21};
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    sampleValid = 1'b1;
    // Reset values, the unmapped offset included.
    for (int i = 0; i < 5; i++) begin
      host.rdReg(addrs[i], rdv);
      check(rdv, 8'h00);
    end
    host.wrReg(REG_CONFIG, 8'hFF);
    host.rdReg(REG_CONFIG, rdv);
    check(rdv, 8'h1F);
    host.wrReg(REG_THRESHOLD, 8'h8A);
    host.rdReg(REG_THRESHOLD, rdv);
    check(rdv, 8'h8A);
    host.wrReg(REG_COUNT, 8'hC3);
    host.rdReg(REG_COUNT, rdv);
    check(rdv, 8'hC3);
    host.wrReg(REG_SOURCE, 8'hFF);
    src(8'h00);
    $display("test registers done");
    // High-pass path: a jump is seen once, a steady level fades, the release is negative.
    setup(8'h1E, 8'h0A, 8'h00);
    sx(40, 0, 0);
    waitCyc(100);
    src(8'h42);
    src(8'h00);
    sx(0, 0, 0);
    waitCyc(30);
    src(8'h43);
    $display("test highpass done");
    // Strictly greater, signed polarity, event_active and the interrupt.
    setup(8'h1F, 8'h0A, 8'h00);
    sx(11, -11, 10);
    waitCyc(30);
    check({7'h0, transientIrq}, 8'h01);
    sx(0, 0, 0);
    src(8'h4E);
    waitCyc(20);
    src(8'h00);
    check({7'h0, transientIrq}, 8'h00);
    $display("test detect done");
    // Only X enabled, interrupt masked.
    irqEnable = 1'b0;
    setup(8'h13, 8'h0A, 8'h00);
    sx(50, 50, -50);
    waitCyc(30);
    check({7'h0, transientIrq}, 8'h00);
    sx(0, 0, 0);
    src(8'h42);
    irqEnable = 1'b1;
    $display("test enables done");
    // Latched: once event_active is set the other bits freeze.
    setup(8'h1F, 8'h0A, 8'h00);
    hitX(20, 30);
    sx(-20, 20, 0);
    waitCyc(30);
    sx(0, 0, 0);
    src(8'h42);
    // Live flags: axis bits gather and stay, event_active drops.
    setup(8'h0F, 8'h0A, 8'h00);
    hitX(20, 30);
    sx(0, -20, 0);
    waitCyc(30);
    sx(0, 0, 0);
    waitCyc(30);
    check({7'h0, transientIrq}, 8'h00);
    src(8'h0E);
    $display("test latch done");
    // Full 8g span and the low-noise cap.
    setup(8'h1F, 8'h64, 8'h00);
    hitX(70, 30);
    src(8'h00);
    hitX(-120, 30);
    src(8'h43);
    lowNoiseEnable = 1'b1;
    hitX(70, 30);
    src(8'h42);
    lowNoiseEnable = 1'b0;
    $display("test range done");
    // Two or three true steps then one false: only the decrementing counter gets to four.
    for (int s = 1; s >= 0; s--) begin
      setup(8'h1F, {s[0], 7'h0A}, 8'h04);
      repeat (10) begin
        hitX(20, 8);
        waitCyc(3);
      end
      src(s ? 8'h00 : 8'h42);
    end
    $display("test debounce done");
    // Step period by rate and mode: a 200-cycle burst against a count of two.
    rates = '{RATE_800, RATE_12, RATE_12, RATE_12, 8'h06};
    modes = '{OS_NORMAL, OS_NORMAL, OS_FINE_RES, OS_LOW_POWER, OS_LOW_NOISE_LP};
    exps  = '{8'h42, 8'h42, 8'h42, 8'h00, 8'h00};
    setup(8'h1F, 8'h8A, 8'h02);
    for (int i = 0; i < 5; i++) begin
      sampleRateSetting = rates[i][2:0];
      osMode = modes[i];
      hitX(20, 200);
      sampleRateSetting = RATE_800;
      osMode = OS_NORMAL;
      waitCyc(20);
      src(exps[i]);
      flush();
    end
    $display("test step done");
    endSim();
  end
endmodule
